// ===== core/gpio_hj_regs.svh
// register offsets, field positions, reset values for the two-port gpio block
`ifndef GPIO_HJ_REGS_SVH
`define GPIO_HJ_REGS_SVH

// register indices on the 4-bit register port
`define HIGH_PORT_DIRECTION_OFS 4'h0
`define HIGH_PORT_PINS_OFS 4'h1
`define HIGH_PORT_OUTPUT_LATCH_OFS 4'h2
`define CTRL_PORT_DIRECTION_OFS 4'h3
`define CTRL_PORT_PINS_OFS 4'h4
`define CTRL_PORT_OUTPUT_LATCH_OFS 4'h5
`define ANALOG_PIN_CONFIG_OFS 4'h6
`define EXTERNAL_BUS_CONTROL_OFS 4'h7
`define PWM_ROUTE_CONTROL_OFS 4'h8

// external bus control fields
`define BUS_DISABLE_BIT 7
`define BUS_CTRL_WMASK 8'hb3
// analog config: conversion select field and writable bits
`define ANALOG_PCFG_MSB 3
`define ANALOG_CFG_WMASK 8'h3f
// pwm route control: relocation select
`define PWM_RELOCATE_BIT 0
// ctrl port pin that never joins the bus
`define CTRL_PORT_FREE_PIN 5

// reset values
`define DIRECTION_RST 8'hff
`define LATCH_RST 8'h00
`define ANALOG_CFG_RST 8'h00
`define BUS_CTRL_RST 8'h00
`define PWM_ROUTE_RST 8'h00

`endif

// ===== core/gpio_hj_pkg.sv
// types for the two-port gpio block
package gpio_hj_pkg;

    typedef logic [7:0] byte_t;
    typedef logic [3:0] nibble_t;

    // complete state of the block
    typedef struct packed {
        byte_t highDir;
        byte_t highLat;
        byte_t ctrlDir;
        byte_t ctrlLat;
        byte_t analogCfg;
        byte_t busCtrl;
        byte_t pwmRoute;
        byte_t highSync1;
        byte_t highSync2;
        byte_t highSync3;
        byte_t highLevel;
        byte_t ctrlSync1;
        byte_t ctrlSync2;
        byte_t ctrlSync3;
        byte_t ctrlLevel;
        byte_t highOut;
        byte_t highOe;
        byte_t ctrlOut;
        byte_t ctrlOe;
        nibble_t ttlSel;
        nibble_t analogSel;
        byte_t readData;
        logic busEn;
    } state_s;

endpackage : gpio_hj_pkg

// ===== core/gpio_ports_h_j_bus_mux.sv
// two 8-bit gpio ports sharing pins with the external memory bus
//
// Behaviour
// - high direction 1 releases pin driver
// - high direction 0 drives output latch bit
// - latch register reads stored latch value
// - upper high pins select analog or digital
// - lower high pins carry bus address 19:16
// - reset: upper pins analog, read zero
// - reset: lower pins carry bus address
// - lower pins schmitt in io, ttl otherwise
// - pwm outputs on upper pins unless relocated; analog mode releases them instead
// - ctrl direction behaves like high direction
// - ctrl latch register reads stored latch
// - ctrl pins carry strobes while bus enabled
// - ctrl bit five always ordinary io
// - peripheral may force pin direction
// - override never stored in direction register
// - reset: ctrl direction all inputs; with bus enabled, all ctrl pins but bit five carry strobes
// - no external bus: control reads zero
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "gpio_hj_regs.svh"
`default_nettype none

module gpio_ports_h_j_bus_mux #(
    parameter bit HAS_EXTERNAL_BUS = 1'b1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [7:0] regReadData,
    // high port pins
    input wire gpio_hj_pkg::byte_t highPinIn,
    output logic [7:0] highPinOut,
    output logic [7:0] highPinOe,
    // ctrl port pins
    input wire gpio_hj_pkg::byte_t ctrlPinIn,
    output logic [7:0] ctrlPinOut,
    output logic [7:0] ctrlPinOe,
    // external bus side
    input wire logic [3:0] busAddressUpper,
    input wire logic [7:0] busStrobeOut,
    input wire logic parallelSlaveMode,
    // enhanced pwm outputs: 3 pwm_a_out_b, 2 pwm_a_out_c, 1 pwm_c_out_b, 0 pwm_c_out_c
    input wire logic [3:0] pwmOut,
    input wire logic [3:0] pwmActive,
    // peripheral direction overrides
    input wire logic [7:0] highForceOut,
    input wire logic [7:0] highForceIn,
    input wire logic [7:0] highPeriphData,
    input wire logic [7:0] ctrlForceOut,
    input wire logic [7:0] ctrlForceIn,
    input wire logic [7:0] ctrlPeriphData,
    // status to converter and pad buffers
    output logic [3:0] analogChannelsUpper,
    output logic [3:0] lowerTtlSelect,
    output logic busEnabled
);

    import gpio_hj_pkg::*;

    state_s stateQ;
    state_s stateD;
    logic busOn;
    logic upperAnalog;
    byte_t highPins;

    // three-stage filter: a new level counts once stages two and three agree
    function automatic byte_t filterLevel(input byte_t s2, input byte_t s3, input byte_t prev);
        byte_t r;
        r = prev;
        for (int i = 0; i < 8; i++) begin
            if (s2[i] == s3[i]) begin
                r[i] = s3[i];
            end
        end
        return r;
    endfunction : filterLevel

    // gpio drive enable: overrides win but never touch the register
    function automatic byte_t gpioEnable(input byte_t dir, input byte_t fOut, input byte_t fIn);
        byte_t r;
        r = ~dir;
        r = r & ~fIn;
        r = r | fOut;
        return r;
    endfunction : gpioEnable

    // gpio drive data: forced outputs carry peripheral data
    function automatic byte_t gpioData(input byte_t lat, input byte_t fOut, input byte_t pData);
        byte_t r;
        r = (lat & ~fOut) | (pData & fOut);
        return r;
    endfunction : gpioData

    // bus mode and analog mode decode
    always_comb begin
        busOn = HAS_EXTERNAL_BUS && !stateQ.busCtrl[`BUS_DISABLE_BIT];
        upperAnalog = (stateQ.analogCfg[`ANALOG_PCFG_MSB:0] == 4'h0);
    end

    // high port pin view; upper nibble reads zero in analog mode
    always_comb begin
        highPins = stateQ.highLevel;
        if (upperAnalog) begin
            highPins[7:4] = 4'h0;
        end
    end

    // next-state logic
    always_comb begin
        byte_t en;
        byte_t dat;
        en = 8'h00;
        dat = 8'h00;
        stateD = stateQ;

        // input synchronisers
        stateD.highSync1 = highPinIn;
        stateD.highSync2 = stateQ.highSync1;
        stateD.highSync3 = stateQ.highSync2;
        stateD.highLevel = filterLevel(stateQ.highSync2, stateQ.highSync3, stateQ.highLevel);
        stateD.ctrlSync1 = ctrlPinIn;
        stateD.ctrlSync2 = stateQ.ctrlSync1;
        stateD.ctrlSync3 = stateQ.ctrlSync2;
        stateD.ctrlLevel = filterLevel(stateQ.ctrlSync2, stateQ.ctrlSync3, stateQ.ctrlLevel);

        // register writes
        if (regWrite) begin
            case (regAddr)
                `HIGH_PORT_DIRECTION_OFS: begin
                    stateD.highDir = regWriteData;
                end
                `HIGH_PORT_PINS_OFS: begin
                    stateD.highLat = regWriteData;
                end
                `HIGH_PORT_OUTPUT_LATCH_OFS: begin
                    stateD.highLat = regWriteData;
                end
                `CTRL_PORT_DIRECTION_OFS: begin
                    stateD.ctrlDir = regWriteData;
                end
                `CTRL_PORT_PINS_OFS: begin
                    stateD.ctrlLat = regWriteData;
                end
                `CTRL_PORT_OUTPUT_LATCH_OFS: begin
                    stateD.ctrlLat = regWriteData;
                end
                `ANALOG_PIN_CONFIG_OFS: begin
                    stateD.analogCfg = regWriteData & `ANALOG_CFG_WMASK;
                end
                `EXTERNAL_BUS_CONTROL_OFS: begin
                    if (HAS_EXTERNAL_BUS) begin
                        stateD.busCtrl = regWriteData & `BUS_CTRL_WMASK;
                    end
                end
                `PWM_ROUTE_CONTROL_OFS: begin
                    stateD.pwmRoute = {7'h00, regWriteData[`PWM_RELOCATE_BIT]};
                end
                default: begin
                end
            endcase
        end

        // register reads, data stands in the following cycle only
        stateD.readData = 8'h00;
        if (regRead) begin
            case (regAddr)
                `HIGH_PORT_DIRECTION_OFS: begin
                    stateD.readData = stateQ.highDir;
                end
                `HIGH_PORT_PINS_OFS: begin
                    stateD.readData = highPins;
                end
                `HIGH_PORT_OUTPUT_LATCH_OFS: begin
                    stateD.readData = stateQ.highLat;
                end
                `CTRL_PORT_DIRECTION_OFS: begin
                    stateD.readData = stateQ.ctrlDir;
                end
                `CTRL_PORT_PINS_OFS: begin
                    stateD.readData = stateQ.ctrlLevel;
                end
                `CTRL_PORT_OUTPUT_LATCH_OFS: begin
                    stateD.readData = stateQ.ctrlLat;
                end
                `ANALOG_PIN_CONFIG_OFS: begin
                    stateD.readData = stateQ.analogCfg;
                end
                `EXTERNAL_BUS_CONTROL_OFS: begin
                    stateD.readData = HAS_EXTERNAL_BUS ? stateQ.busCtrl : 8'h00;
                end
                `PWM_ROUTE_CONTROL_OFS: begin
                    stateD.readData = stateQ.pwmRoute;
                end
                default: begin
                    stateD.readData = 8'h00;
                end
            endcase
        end

        // high port: ordinary io drive first
        en = gpioEnable(stateQ.highDir, highForceOut, highForceIn);
        dat = gpioData(stateQ.highLat, highForceOut, highPeriphData);

        // lower nibble carries address 19:16 in bus mode
        if (busOn) begin
            en[3:0] = 4'hf;
            dat[3:0] = busAddressUpper;
        end

        // upper nibble: analog releases, pwm drives unless relocated
        for (int i = 0; i < 4; i++) begin
            if (upperAnalog) begin
                en[i + 4] = 1'b0;
                dat[i + 4] = 1'b0;
            end else if (pwmActive[i] && !stateQ.pwmRoute[`PWM_RELOCATE_BIT]) begin
                en[i + 4] = 1'b1;
                dat[i + 4] = pwmOut[i];
            end
        end
        stateD.highOe = en;
        stateD.highOut = dat;

        // lower nibble input buffer type
        stateD.ttlSel = (busOn || parallelSlaveMode) ? 4'hf : 4'h0;
        stateD.analogSel = upperAnalog ? 4'hf : 4'h0;

        // ctrl port: io unless bus enabled, free pin stays io
        en = gpioEnable(stateQ.ctrlDir, ctrlForceOut, ctrlForceIn);
        dat = gpioData(stateQ.ctrlLat, ctrlForceOut, ctrlPeriphData);
        if (busOn) begin
            for (int i = 0; i < 8; i++) begin
                if (i != `CTRL_PORT_FREE_PIN) begin
                    en[i] = 1'b1;
                    dat[i] = busStrobeOut[i];
                end
            end
        end
        stateD.ctrlOe = en;
        stateD.ctrlOut = dat;

        // registered bus status, tracks the control register it mirrors
        stateD.busEn = HAS_EXTERNAL_BUS && !stateD.busCtrl[`BUS_DISABLE_BIT];
    end

    // state register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stateQ.highDir <= `DIRECTION_RST;
            stateQ.highLat <= `LATCH_RST;
            stateQ.ctrlDir <= `DIRECTION_RST;
            stateQ.ctrlLat <= `LATCH_RST;
            stateQ.analogCfg <= `ANALOG_CFG_RST;
            stateQ.busCtrl <= `BUS_CTRL_RST;
            stateQ.pwmRoute <= `PWM_ROUTE_RST;
            stateQ.highSync1 <= 8'h00;
            stateQ.highSync2 <= 8'h00;
            stateQ.highSync3 <= 8'h00;
            stateQ.highLevel <= 8'h00;
            stateQ.ctrlSync1 <= 8'h00;
            stateQ.ctrlSync2 <= 8'h00;
            stateQ.ctrlSync3 <= 8'h00;
            stateQ.ctrlLevel <= 8'h00;
            stateQ.highOut <= 8'h00;
            stateQ.highOe <= 8'h00;
            stateQ.ctrlOut <= 8'h00;
            stateQ.ctrlOe <= 8'h00;
            stateQ.ttlSel <= 4'h0;
            stateQ.analogSel <= 4'h0;
            stateQ.readData <= 8'h00;
            stateQ.busEn <= HAS_EXTERNAL_BUS;
        end else begin
            stateQ <= stateD;
        end
    end

    // outputs straight from the state register
    assign regReadData = stateQ.readData;
    assign highPinOut = stateQ.highOut;
    assign highPinOe = stateQ.highOe;
    assign ctrlPinOut = stateQ.ctrlOut;
    assign ctrlPinOe = stateQ.ctrlOe;
    assign analogChannelsUpper = stateQ.analogSel;
    assign lowerTtlSelect = stateQ.ttlSel;
    assign busEnabled = stateQ.busEn;

endmodule : gpio_ports_h_j_bus_mux

`default_nettype wire

// ===== testbench/board_io_model.sv
// board-side pin model: resolves one port's pads from device drive and board drive
`timescale 1ns/1ns
`default_nettype none
module board_io_model (
    // device side
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    // board side
    input wire logic [7:0] boardDrive,
    output logic [7:0] pinIn
);
    // driven bits take the device value, released bits the board value
    assign pinIn = (pinOe & pinOut) | (~pinOe & boardDrive);
endmodule : board_io_model
`default_nettype wire

// ===== testbench/gpio_hj_properties.sv
// pin drive and bus mux properties of the two-port gpio block
`timescale 1ns/1ns
`default_nettype none
module gpio_hj_properties (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // register port
    input wire logic regRead,
    input wire logic [7:0] regReadData,
    // pins
    input wire logic [7:0] highPinOut,
    input wire logic [7:0] highPinOe,
    input wire logic [7:0] ctrlPinOut,
    input wire logic [7:0] ctrlPinOe,
    // bus and peripheral side
    input wire logic [3:0] busAddressUpper,
    input wire logic [7:0] busStrobeOut,
    input wire logic parallelSlaveMode,
    input wire logic [7:0] ctrlForceOut,
    input wire logic [7:0] ctrlForceIn,
    input wire logic [7:0] ctrlPeriphData,
    // status
    input wire logic [3:0] analogChannelsUpper,
    input wire logic [3:0] lowerTtlSelect,
    input wire logic busEnabled
);
    // one clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // drive and status outputs lag their cause by one cycle
    property p_lower_addr;
        $past(reset_n) && $past(busEnabled) |-> highPinOe[3:0] == 4'hf && highPinOut[3:0] == $past(busAddressUpper);
    endproperty
    a_lower_addr: assert property (p_lower_addr) else $error("lower pins off bus address");
    property p_strobes;
        $past(reset_n) && $past(busEnabled) |->
            (ctrlPinOe | 8'h20) == 8'hff && (ctrlPinOut & 8'hdf) == ($past(busStrobeOut) & 8'hdf);
    endproperty
    a_strobes: assert property (p_strobes) else $error("ctrl pins off strobes");
    property p_free_pin;
        $past(reset_n) && $past(ctrlForceOut[5]) |-> ctrlPinOe[5] && ctrlPinOut[5] == $past(ctrlPeriphData[5]);
    endproperty
    a_free_pin: assert property (p_free_pin) else $error("ctrl bit five not free");
    property p_force_out;
        $past(reset_n) && !$past(busEnabled) |-> (ctrlPinOe & $past(ctrlForceOut)) == $past(ctrlForceOut);
    endproperty
    a_force_out: assert property (p_force_out) else $error("force out lost");
    property p_force_in;
        $past(reset_n) && !$past(busEnabled) |-> (ctrlPinOe & $past(ctrlForceIn & ~ctrlForceOut)) == 8'h00;
    endproperty
    a_force_in: assert property (p_force_in) else $error("force in lost");
    property p_analog;
        analogChannelsUpper != 4'h0 |-> (highPinOe[7:4] & analogChannelsUpper) == 4'h0;
    endproperty
    a_analog: assert property (p_analog) else $error("analog pin driven");
    property p_ttl;
        $past(reset_n) |-> lowerTtlSelect == {4{$past(busEnabled) || $past(parallelSlaveMode)}};
    endproperty
    a_ttl: assert property (p_ttl) else $error("input buffer select wrong");
    property p_read_idle;
        !regRead |=> regReadData == 8'h00;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");
    // main scenarios
    c_bus_off: cover property (!busEnabled);
    c_read: cover property (regRead);
    c_digital: cover property (analogChannelsUpper == 4'h0);
endmodule : gpio_hj_properties
bind gpio_ports_h_j_bus_mux gpio_hj_properties i_props (.clk(clk), .reset_n(reset_n), .regRead(regRead),
    .regReadData(regReadData), .highPinOut(highPinOut), .highPinOe(highPinOe), .ctrlPinOut(ctrlPinOut),
    .ctrlPinOe(ctrlPinOe), .busAddressUpper(busAddressUpper), .busStrobeOut(busStrobeOut),
    .parallelSlaveMode(parallelSlaveMode), .ctrlForceOut(ctrlForceOut), .ctrlForceIn(ctrlForceIn),
    .ctrlPeriphData(ctrlPeriphData), .analogChannelsUpper(analogChannelsUpper),
    .lowerTtlSelect(lowerTtlSelect), .busEnabled(busEnabled));
`default_nettype wire

// ===== testbench/tb_top.sv
// self-checking bench for the two-port gpio block
`timescale 1ns/1ns
`include "gpio_hj_regs.svh"
`default_nettype none
module tb_top;
    import gpio_hj_pkg::*;
    logic clk, reset_n, regWrite, regRead, parallelSlaveMode, busEnabled;
    logic [3:0] regAddr, busAddressUpper, pwmOut, pwmActive, analogChannelsUpper, lowerTtlSelect;
    logic [7:0] regWriteData, busStrobeOut, highForceOut, highForceIn, highPeriphData, highBoard, ctrlBoard;
    logic [7:0] ctrlForceOut, ctrlForceIn, ctrlPeriphData, regReadData, highPinOut, highPinOe, ctrlPinOut, ctrlPinOe;
    byte_t highPinIn, ctrlPinIn;
    int errorCnt = 0;
    int compares = 0;
    // device and board pads
    gpio_ports_h_j_bus_mux i_dut (.clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
        .regWrite(regWrite), .regRead(regRead), .regReadData(regReadData), .highPinIn(highPinIn),
        .highPinOut(highPinOut), .highPinOe(highPinOe), .ctrlPinIn(ctrlPinIn), .ctrlPinOut(ctrlPinOut),
        .ctrlPinOe(ctrlPinOe), .busAddressUpper(busAddressUpper), .busStrobeOut(busStrobeOut),
        .parallelSlaveMode(parallelSlaveMode), .pwmOut(pwmOut), .pwmActive(pwmActive),
        .highForceOut(highForceOut), .highForceIn(highForceIn), .highPeriphData(highPeriphData),
        .ctrlForceOut(ctrlForceOut), .ctrlForceIn(ctrlForceIn), .ctrlPeriphData(ctrlPeriphData),
        .analogChannelsUpper(analogChannelsUpper), .lowerTtlSelect(lowerTtlSelect), .busEnabled(busEnabled));
    board_io_model i_highPads (.pinOut(highPinOut), .pinOe(highPinOe), .boardDrive(highBoard), .pinIn(highPinIn));
    board_io_model i_ctrlPads (.pinOut(ctrlPinOut), .pinOe(ctrlPinOe), .boardDrive(ctrlBoard), .pinIn(ctrlPinIn));
    // comparison and bus cycles
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            errorCnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        check(regReadData, exp);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    // defaults after reset
    task automatic tReset;
        settle(2);
        check({analogChannelsUpper, lowerTtlSelect}, 8'hff);
        check(highPinOe, 8'h0f);
        check({7'h00, busEnabled}, 8'h01);
        rd(`HIGH_PORT_DIRECTION_OFS, 8'hff);
        rd(`CTRL_PORT_DIRECTION_OFS, 8'hff);
        rd(`HIGH_PORT_PINS_OFS, 8'h00);
        rd(`EXTERNAL_BUS_CONTROL_OFS, 8'h00);
    endtask : tReset
    // high port as plain io, latch against pins
    task automatic tHigh;
        wr(`EXTERNAL_BUS_CONTROL_OFS, 8'hff);
        rd(`EXTERNAL_BUS_CONTROL_OFS, 8'hb3);
        wr(`ANALOG_PIN_CONFIG_OFS, 8'h0f);
        wr(`HIGH_PORT_OUTPUT_LATCH_OFS, 8'ha5);
        wr(`HIGH_PORT_DIRECTION_OFS, 8'hf0);
        highBoard <= 8'h3c;
        settle(6);
        check(highPinOe, 8'h0f);
        check(highPinOut & 8'h0f, 8'h05);
        check({4'h0, lowerTtlSelect}, 8'h00);
        rd(`HIGH_PORT_OUTPUT_LATCH_OFS, 8'ha5);
        rd(`HIGH_PORT_PINS_OFS, 8'h35);
        wr(`HIGH_PORT_PINS_OFS, 8'h5a);
        rd(`HIGH_PORT_OUTPUT_LATCH_OFS, 8'h5a);
    endtask : tHigh
    // ctrl port with peripheral overrides
    task automatic tCtrl;
        wr(`CTRL_PORT_OUTPUT_LATCH_OFS, 8'h3c);
        wr(`CTRL_PORT_DIRECTION_OFS, 8'h00);
        ctrlBoard <= 8'h00;
        ctrlForceIn <= 8'h04;
        ctrlForceOut <= 8'h20;
        settle(6);
        check(ctrlPinOe, 8'hfb);
        check(ctrlPinOut & 8'hfb, 8'h18);
        rd(`CTRL_PORT_DIRECTION_OFS, 8'h00);
        rd(`CTRL_PORT_OUTPUT_LATCH_OFS, 8'h3c);
        rd(`CTRL_PORT_PINS_OFS, 8'h18);
    endtask : tCtrl
    // bus on: address and strobes take the pins, bit five stays free
    task automatic tBus;
        ctrlForceIn <= 8'h00;
        busAddressUpper <= 4'h9;
        busStrobeOut <= 8'ha6;
        wr(`EXTERNAL_BUS_CONTROL_OFS, 8'h00);
        settle(2);
        check(highPinOut & 8'h0f, 8'h09);
        check(ctrlPinOe, 8'hff);
        check(ctrlPinOut, 8'h86);
        check({7'h00, busEnabled}, 8'h01);
        wr(`EXTERNAL_BUS_CONTROL_OFS, 8'h80);
        parallelSlaveMode <= 1'b1;
        settle(2);
        check({4'h0, lowerTtlSelect}, 8'h0f);
        check({7'h00, busEnabled}, 8'h00);
        parallelSlaveMode <= 1'b0;
    endtask : tBus
    // pwm on upper pins, relocation and analog priority
    task automatic tPwm;
        pwmActive <= 4'hf;
        pwmOut <= 4'ha;
        settle(2);
        check(highPinOe & 8'hf0, 8'hf0);
        check(highPinOut & 8'hf0, 8'ha0);
        wr(`PWM_ROUTE_CONTROL_OFS, 8'h01);
        settle(2);
        check(highPinOe & 8'hf0, 8'h00);
        wr(`PWM_ROUTE_CONTROL_OFS, 8'h00);
        wr(`ANALOG_PIN_CONFIG_OFS, 8'h00);
        settle(2);
        check({analogChannelsUpper, highPinOe[7:4]}, 8'hf0);
        rd(4'hf, 8'h00);
    endtask : tPwm
    // verdict
    task automatic endSim;
        if (errorCnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : endSim
    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // watchdog
    initial begin
        #100000;
        errorCnt++;
        endSim;
    end
    // main sequence
    initial begin
        {reset_n, regWrite, regRead, parallelSlaveMode, regAddr, regWriteData} = '0;
        {busAddressUpper, busStrobeOut, pwmOut, pwmActive} = '0;
        {highForceOut, highForceIn, highPeriphData, ctrlForceOut, ctrlForceIn, ctrlPeriphData} = '0;
        highBoard = 8'hff;
        ctrlBoard = 8'hff;
        repeat (2) @(posedge clk);
        @(negedge clk);
        reset_n = 1'b1;
        tReset;
        tHigh;
        tCtrl;
        tBus;
        tPwm;
        endSim;
    end
endmodule : tb_top
`default_nettype wire
